// ---- logic/icir_pkg.sv ----
// package for the isochronous context interrupt register block
package icir_pkg;
	// register byte offsets
	localparam logic [7:0] ADDR_TX_PEND_SET = 8'h00;
	localparam logic [7:0] ADDR_TX_PEND_CLR = 8'h04;
	localparam logic [7:0] ADDR_TX_EN_SET = 8'h08;
	localparam logic [7:0] ADDR_TX_EN_CLR = 8'h0C;
	localparam logic [7:0] ADDR_RX_PEND_SET = 8'h10;
	localparam logic [7:0] ADDR_RX_PEND_CLR = 8'h14;
	localparam logic [7:0] ADDR_RX_EN_SET = 8'h18;
	localparam logic [7:0] ADDR_RX_EN_CLR = 8'h1C;
	localparam logic [7:0] ADDR_GLB_PEND = 8'h20;
	localparam logic [7:0] ADDR_GLB_EN_SET = 8'h24;
	localparam logic [7:0] ADDR_GLB_EN_CLR = 8'h28;
	// global field positions
	localparam int GLB_TX_BIT = 6;
	localparam int GLB_RX_BIT = 7;
	localparam int GLB_GATE_BIT = 31;
	// reset values
	localparam logic GATE_RESET = 1'b0;
	localparam logic [31:0] RDATA_RESET = 32'h0000_0000;
	// command interrupt control encoding for always interrupt
	localparam logic [1:0] IRQ_CTL_ALWAYS = 2'h3;
	// completion report from the dma engines
	typedef struct packed {
		logic done;
		logic [4:0] ctx;
		logic [1:0] irq_ctl;
	} icir_cmpl_t;
	// register bus request
	typedef struct packed {
		logic wr;
		logic rd;
		logic [7:0] addr;
		logic [31:0] wdata;
	} icir_bus_t;
endpackage

// ---- logic/icir_top.sv ----
// isochronous context interrupt registers with summary and gate
//
// Implementation choices: the register offsets and the plain strobed port.
`timescale 1ns/1ps
`default_nettype none
// How it works
// - rx pending and enable registers are 32 bits, each with set and clear addresses.
// - writing ones to a set address sets those bits.
// - writing ones to a clear address clears those bits.
// - zero data bits leave register bits unchanged at all four addresses.
// - each rx pending bit records one receive context's completion.
// - final input command with always-interrupt control sets that rx context bit.
// - nonzero rx enable AND pending sets the rx summary flag.
// - summary drives the interrupt only if its global enable bit allows.
// - reading rx pending set address returns raw pending bits.
// - reading rx pending clear address returns pending ANDed with enable.
// - an enable bit of one lets its pending bit reach the summary.
// - enable bits of unimplemented contexts always read zero.
// - enable bits of implemented contexts hold written ones.
// - pending and enable contents need no reset initialisation.
// - reset clears the global interrupt gate.
// - final output command with always-interrupt control sets that tx context bit.
// - nonzero tx enable AND pending sets the tx summary flag.
// - with the gate clear no interrupt is raised after the first cycle it is clear.
module icir_top #(
	parameter logic [31:0] TX_IMPL = 32'h0000_00FF,
	parameter logic [31:0] RX_IMPL = 32'h0000_000F
) (
	input wire logic CLK,
	input wire logic NRST,
	input wire icir_pkg::icir_bus_t BUS,
	output logic [31:0] RDATA,
	input wire icir_pkg::icir_cmpl_t TX_CMPL,
	input wire icir_pkg::icir_cmpl_t RX_CMPL,
	output logic IRQ
);
	import icir_pkg::*;

	// elaboration check: at least one context of each kind
	if (TX_IMPL == 32'h0 || RX_IMPL == 32'h0) begin : g_bad
		$error("icir_top: no implemented contexts");
	end

	logic [31:0] tx_context_irq_pending_bits;
	logic [31:0] tx_context_irq_enable_bits;
	logic [31:0] rx_context_irq_pending_bits;
	logic [31:0] rx_context_irq_enable_bits;
	logic [31:0] global_irq_enable;
	logic global_irq_gate;
	logic tx_summary_flag;
	logic rx_summary_flag;
	logic [31:0] global_irq_pending;
	logic [31:0] tx_hw_set;
	logic [31:0] rx_hw_set;
	logic [31:0] rdata_next;
	logic irq_next;
	// decoded global enable writes, kept as nets so single bits can be picked
	logic [31:0] glb_set_w;
	logic [31:0] glb_clr_w;

	// write strobe decode, used for every register
	function automatic logic [31:0] wmask(input icir_bus_t b, input logic [7:0] a);
		wmask = (b.wr && b.addr == a) ? b.wdata : 32'h0;
	endfunction

	// completion decode: one-hot context bit when command asks for interrupt
	function automatic logic [31:0] cmpl_bit(input icir_cmpl_t c);
		cmpl_bit = (c.done && c.irq_ctl == IRQ_CTL_ALWAYS) ? (32'h1 << c.ctx) : 32'h0;
	endfunction

	assign tx_hw_set = cmpl_bit(TX_CMPL) & TX_IMPL;
	assign rx_hw_set = cmpl_bit(RX_CMPL) & RX_IMPL;

	// pending bits carry no reset; software clears them before unmasking
	always_ff @(posedge CLK) begin
		tx_context_irq_pending_bits <= ((tx_context_irq_pending_bits & ~wmask(BUS, ADDR_TX_PEND_CLR))
			| wmask(BUS, ADDR_TX_PEND_SET) | tx_hw_set) & TX_IMPL;
	end

	// rx pending: clear first, then sets win
	always_ff @(posedge CLK) begin
		rx_context_irq_pending_bits <= ((rx_context_irq_pending_bits & ~wmask(BUS, ADDR_RX_PEND_CLR))
			| wmask(BUS, ADDR_RX_PEND_SET) | rx_hw_set) & RX_IMPL;
	end

	// enable bits, unimplemented positions forced to zero
	always_ff @(posedge CLK) begin
		tx_context_irq_enable_bits <= ((tx_context_irq_enable_bits & ~wmask(BUS, ADDR_TX_EN_CLR))
			| wmask(BUS, ADDR_TX_EN_SET)) & TX_IMPL;
		rx_context_irq_enable_bits <= ((rx_context_irq_enable_bits & ~wmask(BUS, ADDR_RX_EN_CLR))
			| wmask(BUS, ADDR_RX_EN_SET)) & RX_IMPL;
	end

	// global enable: only the gate is reset, the rest is don't-care
	assign glb_set_w = wmask(BUS, ADDR_GLB_EN_SET);
	assign glb_clr_w = wmask(BUS, ADDR_GLB_EN_CLR);
	always_ff @(posedge CLK) begin
		global_irq_enable <= (global_irq_enable & ~glb_clr_w) | glb_set_w;
	end
	// the gate alone is reset so nothing fires until software opens it
	always_ff @(posedge CLK) begin
		if (!NRST) begin
			global_irq_gate <= GATE_RESET;
		end else if (glb_set_w[GLB_GATE_BIT]) begin
			global_irq_gate <= 1'b1;
		end else if (glb_clr_w[GLB_GATE_BIT]) begin
			global_irq_gate <= 1'b0;
		end
	end

	// summary flags follow the masked pending bits live
	assign tx_summary_flag = |(tx_context_irq_enable_bits & tx_context_irq_pending_bits);
	assign rx_summary_flag = |(rx_context_irq_enable_bits & rx_context_irq_pending_bits);
	always_comb begin
		global_irq_pending = 32'h0;
		global_irq_pending[GLB_TX_BIT] = tx_summary_flag;
		global_irq_pending[GLB_RX_BIT] = rx_summary_flag;
	end

	// interrupt gated by global enable and the gate
	assign irq_next = global_irq_gate && |(global_irq_pending & global_irq_enable);
	always_ff @(posedge CLK) begin
		if (!NRST) begin
			IRQ <= 1'b0;
		end else begin
			IRQ <= irq_next;
		end
	end

	// read mux; unmapped addresses read zero
	always_comb begin
		rdata_next = RDATA_RESET;
		unique case (BUS.addr)
			ADDR_TX_PEND_SET: rdata_next = tx_context_irq_pending_bits;
			ADDR_TX_PEND_CLR: rdata_next = tx_context_irq_pending_bits & tx_context_irq_enable_bits;
			ADDR_TX_EN_SET, ADDR_TX_EN_CLR: rdata_next = tx_context_irq_enable_bits;
			ADDR_RX_PEND_SET: rdata_next = rx_context_irq_pending_bits;
			ADDR_RX_PEND_CLR: rdata_next = rx_context_irq_pending_bits & rx_context_irq_enable_bits;
			ADDR_RX_EN_SET, ADDR_RX_EN_CLR: rdata_next = rx_context_irq_enable_bits;
			ADDR_GLB_PEND: rdata_next = global_irq_pending;
			ADDR_GLB_EN_SET, ADDR_GLB_EN_CLR: begin
				rdata_next = global_irq_enable;
				rdata_next[GLB_GATE_BIT] = global_irq_gate;
			end
			default: rdata_next = RDATA_RESET;
		endcase
	end

	// read data valid in the cycle after the strobe only
	always_ff @(posedge CLK) begin
		if (!NRST) begin
			RDATA <= RDATA_RESET;
		end else if (BUS.rd) begin
			RDATA <= rdata_next;
		end else begin
			RDATA <= RDATA_RESET;
		end
	end

	// checks
	rx_set_bits_a: assert property (@(posedge CLK) disable iff (!NRST)
		BUS.wr && BUS.addr == ADDR_RX_PEND_SET |=> ((rx_context_irq_pending_bits & $past(BUS.wdata) & RX_IMPL)
			== ($past(BUS.wdata) & RX_IMPL))) else $error("rx set write lost bits");
	rx_clear_bits_a: assert property (@(posedge CLK) disable iff (!NRST)
		BUS.wr && BUS.addr == ADDR_RX_PEND_CLR && !RX_CMPL.done |=> ((rx_context_irq_pending_bits & $past(BUS.wdata))
			== 32'h0)) else $error("rx clear write left bits");
	rx_zero_keep_a: assert property (@(posedge CLK) disable iff (!NRST)
		BUS.wr && BUS.addr == ADDR_RX_EN_SET |=> ((rx_context_irq_enable_bits & ~$past(BUS.wdata))
			== ($past(rx_context_irq_enable_bits) & ~$past(BUS.wdata)))) else $error("rx enable zero bit changed");
	rx_hw_event_a: assert property (@(posedge CLK) disable iff (!NRST)
		rx_hw_set != 32'h0 |=> (rx_context_irq_pending_bits & $past(rx_hw_set)) == $past(rx_hw_set))
		else $error("rx completion event lost");
	tx_hw_event_a: assert property (@(posedge CLK) disable iff (!NRST)
		tx_hw_set != 32'h0 |=> (tx_context_irq_pending_bits & $past(tx_hw_set)) == $past(tx_hw_set))
		else $error("tx completion event lost");
	rx_read_raw_a: assert property (@(posedge CLK) disable iff (!NRST)
		BUS.rd && BUS.addr == ADDR_RX_PEND_SET |=> RDATA == $past(rx_context_irq_pending_bits))
		else $error("rx raw read wrong");
	rx_read_masked_a: assert property (@(posedge CLK) disable iff (!NRST)
		BUS.rd && BUS.addr == ADDR_RX_PEND_CLR |=> RDATA == $past(rx_context_irq_pending_bits & rx_context_irq_enable_bits))
		else $error("rx masked read wrong");
	unimpl_zero_a: assert property (@(posedge CLK) disable iff (!NRST)
		(rx_context_irq_enable_bits & ~RX_IMPL) == 32'h0 && (tx_context_irq_enable_bits & ~TX_IMPL) == 32'h0)
		else $error("unimplemented enable bit set");
	gate_off_a: assert property (@(posedge CLK) disable iff (!NRST)
		!global_irq_gate ##1 !global_irq_gate |-> !IRQ) else $error("irq with gate clear");
	irq_follow_a: assert property (@(posedge CLK) disable iff (!NRST)
		global_irq_gate && global_irq_enable[GLB_RX_BIT] && rx_summary_flag |=> IRQ)
		else $error("enabled rx summary gave no irq");

	// tx pending set address sets the written ones
	tx_set_bits_a: assert property (@(posedge CLK) disable iff (!NRST)
		BUS.wr && BUS.addr == ADDR_TX_PEND_SET |=> ((tx_context_irq_pending_bits & $past(BUS.wdata) & TX_IMPL)
			== ($past(BUS.wdata) & TX_IMPL))) else $error("tx set write lost bits");

	// tx pending clear address clears the written ones unless hardware sets
	tx_clear_bits_a: assert property (@(posedge CLK) disable iff (!NRST)
		BUS.wr && BUS.addr == ADDR_TX_PEND_CLR && !TX_CMPL.done |=> ((tx_context_irq_pending_bits
			& $past(BUS.wdata)) == 32'h0)) else $error("tx clear write left bits");

	// rx pending clear leaves the zero-data bits alone
	pend_zero_keep_a: assert property (@(posedge CLK) disable iff (!NRST)
		BUS.wr && BUS.addr == ADDR_RX_PEND_CLR && !RX_CMPL.done |=> ((rx_context_irq_pending_bits
			& ~$past(BUS.wdata)) == ($past(rx_context_irq_pending_bits) & ~$past(BUS.wdata))))
		else $error("rx pending zero bit changed");

	// rx enable set holds written ones on implemented contexts
	rx_en_set_a: assert property (@(posedge CLK) disable iff (!NRST)
		BUS.wr && BUS.addr == ADDR_RX_EN_SET |=> ((rx_context_irq_enable_bits & $past(BUS.wdata) & RX_IMPL)
			== ($past(BUS.wdata) & RX_IMPL))) else $error("rx enable set lost bits");

	// rx enable clear drops the written ones
	rx_en_clear_a: assert property (@(posedge CLK) disable iff (!NRST)
		BUS.wr && BUS.addr == ADDR_RX_EN_CLR |=> ((rx_context_irq_enable_bits & $past(BUS.wdata)) == 32'h0))
		else $error("rx enable clear left bits");

	// tx enable set holds written ones on implemented contexts
	tx_en_set_a: assert property (@(posedge CLK) disable iff (!NRST)
		BUS.wr && BUS.addr == ADDR_TX_EN_SET |=> ((tx_context_irq_enable_bits & $past(BUS.wdata) & TX_IMPL)
			== ($past(BUS.wdata) & TX_IMPL))) else $error("tx enable set lost bits");

	// tx enable clear drops the written ones
	tx_en_clear_a: assert property (@(posedge CLK) disable iff (!NRST)
		BUS.wr && BUS.addr == ADDR_TX_EN_CLR |=> ((tx_context_irq_enable_bits & $past(BUS.wdata)) == 32'h0))
		else $error("tx enable clear left bits");

	// pending bits of missing contexts never appear
	unimpl_pend_a: assert property (@(posedge CLK) disable iff (!NRST)
		(rx_context_irq_pending_bits & ~RX_IMPL) == 32'h0 && (tx_context_irq_pending_bits & ~TX_IMPL) == 32'h0)
		else $error("unimplemented pending bit set");

	// tx reads: raw at the set address, masked at the clear address
	tx_read_raw_a: assert property (@(posedge CLK) disable iff (!NRST)
		BUS.rd && BUS.addr == ADDR_TX_PEND_SET |=> RDATA == $past(tx_context_irq_pending_bits))
		else $error("tx raw read wrong");
	tx_read_masked_a: assert property (@(posedge CLK) disable iff (!NRST)
		BUS.rd && BUS.addr == ADDR_TX_PEND_CLR |=> RDATA == $past(tx_context_irq_pending_bits
			& tx_context_irq_enable_bits)) else $error("tx masked read wrong");

	// rx enable reads at the set address show the stored bits, zero where no context exists
	rx_en_read_a: assert property (@(posedge CLK) disable iff (!NRST)
		BUS.rd && BUS.addr == ADDR_RX_EN_SET |=> RDATA == ($past(rx_context_irq_enable_bits) & RX_IMPL))
		else $error("rx enable read wrong");

	// global pending read carries both summary flags
	glb_read_a: assert property (@(posedge CLK) disable iff (!NRST)
		BUS.rd && BUS.addr == ADDR_GLB_PEND |=> RDATA[GLB_RX_BIT] == $past(rx_summary_flag)
			&& RDATA[GLB_TX_BIT] == $past(tx_summary_flag)) else $error("global pending read wrong");

	// read data stand one cycle only
	rdata_idle_a: assert property (@(posedge CLK) disable iff (!NRST)
		!BUS.rd |=> RDATA == RDATA_RESET) else $error("read data outside slot");

	// enabled tx summary with gate open raises the interrupt
	irq_tx_follow_a: assert property (@(posedge CLK) disable iff (!NRST)
		global_irq_gate && global_irq_enable[GLB_TX_BIT] && tx_summary_flag |=> IRQ)
		else $error("enabled tx summary gave no irq");

	// no enabled summary means no interrupt on the next cycle
	irq_masked_a: assert property (@(posedge CLK) disable iff (!NRST)
		!(global_irq_enable[GLB_TX_BIT] && tx_summary_flag) && !(global_irq_enable[GLB_RX_BIT] && rx_summary_flag)
			|=> !IRQ) else $error("irq without enabled summary");

	// reset closes the gate and quiets the outputs
	reset_gate_a: assert property (@(posedge CLK)
		!NRST |=> !global_irq_gate && !IRQ && RDATA == RDATA_RESET) else $error("reset left gate or outputs");

	// writing the gate bit at the set address opens it
	gate_set_a: assert property (@(posedge CLK) disable iff (!NRST)
		BUS.wr && BUS.addr == ADDR_GLB_EN_SET && BUS.wdata[GLB_GATE_BIT] |=> global_irq_gate)
		else $error("gate did not open");
endmodule
`default_nettype wire

// ---- tb/tb_icir_top.sv ----
// self-checking bench for the isochronous context interrupt registers
`timescale 1ns/1ps
`default_nettype none
module tb_icir_top;
	import icir_pkg::*;
	typedef struct packed {
		logic [7:0] wa;
		logic [31:0] wd;
		logic [7:0] ra;
		logic [31:0] rd;
		logic irq;
	} icir_row_t;
	logic clk = 1'b0;
	logic nrst = 1'b0;
	icir_bus_t bus = '0;
	icir_cmpl_t tx_cmpl = '0;
	icir_cmpl_t rx_cmpl = '0;
	logic [31:0] rdata;
	logic irq;
	int mismatches = 0;
	int checks_done = 0;
	icir_row_t rows [9];
	logic [7:0] clr [5];
	// 250 MHz clock
	always #2 clk = ~clk;
	icir_top #(.TX_IMPL(32'h0000_00FF), .RX_IMPL(32'h0000_000F)) u_icir_top (.CLK(clk), .NRST(nrst), .BUS(bus),
		.RDATA(rdata), .TX_CMPL(tx_cmpl), .RX_CMPL(rx_cmpl), .IRQ(irq));
	// compare helpers, one per result kind
	task automatic cmp32(input logic [31:0] got, input logic [31:0] exp);
		checks_done++;
		if (got !== exp) begin
			mismatches++;
			$display("MISMATCH t=%0t data %h expected %h", $time, got, exp);
		end
	endtask
	task automatic cmp1(input logic got, input logic exp);
		checks_done++;
		if (got !== exp) begin
			mismatches++;
			$display("MISMATCH t=%0t irq %b expected %b", $time, got, exp);
		end
	endtask
	// one-cycle write strobe
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge clk);
		bus <= '{1'b1, 1'b0, a, d};
		@(posedge clk);
		bus <= '0;
	endtask
	// read data stand only in the cycle after the strobe
	task automatic rd(input logic [7:0] a, input logic [31:0] e);
		@(posedge clk);
		bus <= '{1'b0, 1'b1, a, 32'h0000_0000};
		@(posedge clk);
		bus <= '0;
		#1 cmp32(rdata, e);
	endtask
	// one completion pulse from a dma engine
	task automatic ev(input logic tx, input logic [4:0] c, input logic [1:0] k);
		@(posedge clk);
		if (tx) tx_cmpl <= '{1'b1, c, k};
		else rx_cmpl <= '{1'b1, c, k};
		@(posedge clk);
		tx_cmpl <= '0;
		rx_cmpl <= '0;
	endtask
	task automatic close_out;
		$display("checks %0d mismatches %0d", checks_done, mismatches);
		if (mismatches == 0 && checks_done > 0) $display("Result: passed");
		else $display("Result: failed");
		$finish;
	endtask
	initial begin
		rows = '{'{ADDR_RX_EN_SET, 32'hFFFF_FFFF, ADDR_RX_EN_SET, 32'h0000_000F, 1'b0},
			'{ADDR_TX_EN_SET, 32'hFFFF_FFFF, ADDR_TX_EN_SET, 32'h0000_00FF, 1'b0},
			'{ADDR_RX_EN_CLR, 32'h0000_0005, ADDR_RX_EN_CLR, 32'h0000_000A, 1'b0},
			'{ADDR_RX_PEND_SET, 32'h0000_0003, ADDR_RX_PEND_SET, 32'h0000_0003, 1'b0},
			'{ADDR_RX_PEND_SET, 32'h0000_0000, ADDR_RX_PEND_CLR, 32'h0000_0002, 1'b0},
			'{ADDR_RX_PEND_CLR, 32'h0000_0001, ADDR_RX_PEND_SET, 32'h0000_0002, 1'b0},
			'{ADDR_GLB_EN_SET, 32'h8000_0080, ADDR_GLB_PEND, 32'h0000_0080, 1'b1},
			'{ADDR_TX_PEND_SET, 32'h0000_0010, ADDR_GLB_PEND, 32'h0000_00C0, 1'b1},
			'{ADDR_TX_PEND_CLR, 32'hFFFF_FFFF, 8'h3C, 32'h0000_0000, 1'b1}};
		clr = '{ADDR_TX_PEND_CLR, ADDR_TX_EN_CLR, ADDR_RX_PEND_CLR, ADDR_RX_EN_CLR, ADDR_GLB_EN_CLR};
		repeat (10) @(posedge clk);
		#1 cmp1(irq, 1'b0);
		cmp32(rdata, 32'h0000_0000);
		@(posedge clk);
		nrst <= 1'b1;
		// contents are undefined after reset, so clear everything first
		for (int i = 0; i < 5; i++) wr(clr[i], 32'hFFFF_FFFF);
		for (int i = 0; i < 9; i++) begin
			wr(rows[i].wa, rows[i].wd);
			rd(rows[i].ra, rows[i].rd);
			cmp1(irq, rows[i].irq);
			$display("row %0d done", i);
		end
		// completions: only always-interrupt on an implemented context counts
		wr(ADDR_RX_PEND_CLR, 32'hFFFF_FFFF);
		ev(1'b0, 5'd2, IRQ_CTL_ALWAYS);
		ev(1'b0, 5'd0, 2'h2);
		ev(1'b0, 5'd5, IRQ_CTL_ALWAYS);
		rd(ADDR_RX_PEND_SET, 32'h0000_0004);
		cmp1(irq, 1'b0);
		ev(1'b1, 5'd7, IRQ_CTL_ALWAYS);
		rd(ADDR_TX_PEND_SET, 32'h0000_0080);
		cmp1(irq, 1'b0);
		wr(ADDR_GLB_EN_SET, 32'h0000_0040);
		rd(ADDR_GLB_PEND, 32'h0000_0040);
		cmp1(irq, 1'b1);
		$display("completion test done");
		// hardware set and software clear on the same edge
		@(posedge clk);
		bus <= '{1'b1, 1'b0, ADDR_RX_PEND_CLR, 32'h0000_0008};
		rx_cmpl <= '{1'b1, 5'd3, IRQ_CTL_ALWAYS};
		@(posedge clk);
		bus <= '0;
		rx_cmpl <= '0;
		rd(ADDR_RX_PEND_SET, 32'h0000_000C);
		$display("collision test done");
		// gate off silences everything, reset drops the gate
		wr(ADDR_GLB_EN_CLR, 32'h8000_0000);
		repeat (3) @(posedge clk);
		#1 cmp1(irq, 1'b0);
		wr(ADDR_GLB_EN_SET, 32'h8000_0000);
		repeat (3) @(posedge clk);
		#1 cmp1(irq, 1'b1);
		@(posedge clk);
		nrst <= 1'b0;
		repeat (2) @(posedge clk);
		nrst <= 1'b1;
		repeat (3) @(posedge clk);
		#1 cmp1(irq, 1'b0);
		$display("gate and reset test done");
		close_out();
	end
endmodule
`default_nettype wire
